// >>> logic/ids_pkg.sv
// Purpose: shared constants and types for the strobe-driven drive and diagnostic block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: word index times four gives the byte address
package ids_pkg;
	localparam int NCH = 8;
	localparam int DW = 4;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int IDX_W = 4;
	localparam int IDX_LSB = 2;

	// word indices of the register map
	localparam logic [IDX_W-1:0] IDX_GLOBAL_CONFIG = 4'h0;
	localparam logic [IDX_W-1:0] IDX_DRIVE = 4'h1;
	localparam logic [IDX_W-1:0] IDX_COLLECTIVE = 4'h2;
	localparam logic [IDX_W-1:0] IDX_CHAN_FIRST = 4'h3;
	localparam logic [IDX_W-1:0] IDX_CHAN_LAST = 4'ha;
	localparam logic [IDX_W-1:0] IDX_STATUS = 4'hb;

	// field positions
	localparam int CFG_FREEZE_BIT = 0;
	localparam int CFG_RESYNC_BIT = 1;
	localparam int COL_CF_BIT = NCH;
	localparam int CHAN_LED_BIT = DW;
	localparam int STAT_STROBE_BIT = 0;
	localparam int STAT_ISO_BIT = 1;
	localparam int STAT_DRIVE_LSB = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic resync_select;
		logic diag_freeze_enable;
	} ids_cfg_type;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
	} ids_strobe_type;

	localparam ids_cfg_type CFG_RESET = '{resync_select: 1'b0, diag_freeze_enable: 1'b0};
	localparam logic STROBE_RESET = 1'b1;
	localparam logic [NCH-1:0] DRIVE_RESET = 8'h00;
endpackage

// >>> logic/ids_strobe_sync.sv
// Purpose: brings the strobe pin into the clock domain and finds its edges
// Assumes: strobe idles high
// Notes: first stage feeds only the second stage
module ids_strobe_sync (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic strobe_in,
	output ids_pkg::ids_strobe_type strobe
);
	logic meta;
	logic stable;
	logic prev;
	logic next_meta;
	logic next_stable;
	logic next_prev;

	always_comb begin
		next_meta = strobe_in;
		next_stable = meta;
		next_prev = stable;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= ids_pkg::STROBE_RESET;
			stable <= ids_pkg::STROBE_RESET;
			prev <= ids_pkg::STROBE_RESET;
		end else begin
			meta <= next_meta;
			stable <= next_stable;
			prev <= next_prev;
		end
	end

	// edges taken from the settled stages only
	always_comb begin
		strobe.level = stable;
		strobe.rise = stable & ~prev;
		strobe.fall = ~stable & prev;
	end
endmodule // ids_strobe_sync

// >>> logic/ids_drive_diag.sv
// Purpose: drive forwarding and diagnostic register update under strobe control
// Assumes: AXI4-Lite master, one write and one read outstanding at most
// Notes: per-channel fault inputs are levels sampled each clock
//
// The placing of the registers and the AXI4-Lite register port were decided locally.

// What this block does
// (R1) strobe high: drive register is written and forwarded to the power side
// (R2) strobe low: drive writes are stored but forwarding is frozen
// (R3) software reads collective register first, then the flagged channel registers
// (R4) collective register read loads channel registers from sticky capture, except in isochronous mode with strobe low
// (R5) continuous mode refreshes channel registers on every collective read
// (R6) continuous mode clears sticky state only after fault gone and collective read
// (R7) freeze bit at zero gives continuous diagnostics whatever the strobe does
// (R8) isochronous diagnostics when freeze bit set and resync bit clear
// (R9) isochronous and strobe low: channel registers hold after the falling edge, collective holds unless a read drops a delivered entry
// (R10) falling strobe edge in isochronous mode loads channel registers from sticky
// (R11) sticky capture records faults at all times regardless of strobe
// (R12) rising strobe edge in isochronous mode updates channel and collective registers
// (R13) strobe high in isochronous mode: collective mirrors ORed sticky continuously
// (R14) fault captured while frozen appears at next rising strobe edge
// (R15) sticky keeps each event until delivered and cleared by a read
// (R16) strobe low: a read may clear collective entries already delivered
// (R17) read with strobe low in isochronous mode leaves channel registers unchanged
// (R18) new events go to sticky at once and to collective at once while live, gated LED excluded
// (R19) strobe behaviour same for any host interface, touches only user registers
// (R20) strobe is synchronised and its edges detected before use
// (R21) strobe returning high forwards the current drive register
module ids_drive_diag #(
	parameter int NCH = ids_pkg::NCH,
	parameter int DW = ids_pkg::DW
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ids_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [ids_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ids_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [ids_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic strobe_in,
	input wire logic [NCH*DW-1:0] fault_in,
	input wire logic [NCH-1:0] gated_led_status,
	output logic [NCH-1:0] drive_out,
	output logic common_fault_flag
);
	localparam int CW = DW + 1;
	localparam int CIW = $clog2(NCH);

	ids_pkg::ids_strobe_type strobe;

	// bus state
	logic aw_full;
	logic w_full;
	logic [ids_pkg::IDX_W-1:0] aw_idx;
	logic [ids_pkg::DATA_W-1:0] w_data;
	logic w_lane0;
	logic next_awready;
	logic next_wready;
	logic next_aw_full;
	logic next_w_full;
	logic [ids_pkg::IDX_W-1:0] next_aw_idx;
	logic [ids_pkg::DATA_W-1:0] next_w_data;
	logic next_w_lane0;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_arready;
	logic next_rvalid;
	logic [1:0] next_rresp;
	logic [ids_pkg::DATA_W-1:0] next_rdata;
	logic write_fire;
	logic read_fire;
	logic [ids_pkg::IDX_W-1:0] rd_idx;
	logic [ids_pkg::IDX_W-1:0] rd_chan;

	// user registers
	ids_pkg::ids_cfg_type cfg;
	ids_pkg::ids_cfg_type next_cfg;
	logic [NCH-1:0] drive_reg;
	logic [NCH-1:0] next_drive_reg;
	logic [NCH-1:0] next_drive_out;

	// diagnostic state
	logic [DW-1:0] sticky [NCH];
	logic [DW-1:0] next_sticky [NCH];
	logic [CW-1:0] chan_reg [NCH];
	logic [CW-1:0] next_chan_reg [NCH];
	logic [NCH-1:0] col;
	logic [NCH-1:0] next_col;
	logic next_cf;
	logic iso_en;
	logic live;
	logic chan_load;
	logic col_read;
	logic col_read_live;
	logic col_read_frozen;

	ids_strobe_sync u_strobe_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe_in(strobe_in),
		.strobe(strobe) // R20
	);

	// write channel: address and data taken in either order
	always_comb begin
		write_fire = aw_full & w_full & ~s_axi_bvalid;
		next_aw_full = aw_full | (s_axi_awvalid & s_axi_awready);
		next_w_full = w_full | (s_axi_wvalid & s_axi_wready);
		next_aw_idx = aw_idx;
		next_w_data = w_data;
		next_w_lane0 = w_lane0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_idx = s_axi_awaddr[ids_pkg::IDX_LSB +: ids_pkg::IDX_W];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_data = s_axi_wdata;
			next_w_lane0 = s_axi_wstrb[0];
		end
		// response held until the master takes it
		next_bvalid = s_axi_bvalid & ~s_axi_bready;
		next_bresp = s_axi_bresp;
		if (write_fire) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_idx > ids_pkg::IDX_STATUS) ? ids_pkg::RESP_SLVERR
				: ids_pkg::RESP_OKAY;
		end
		next_awready = ~next_aw_full & ~next_bvalid;
		next_wready = ~next_w_full & ~next_bvalid;
	end

	// write side effects on user registers
	always_comb begin
		next_cfg = cfg;
		next_drive_reg = drive_reg;
		// lane 0 holds every field, other lanes ignored
		if (write_fire && w_lane0) begin
			if (aw_idx == ids_pkg::IDX_GLOBAL_CONFIG) begin
				next_cfg.diag_freeze_enable = w_data[ids_pkg::CFG_FREEZE_BIT];
				next_cfg.resync_select = w_data[ids_pkg::CFG_RESYNC_BIT];
			end
			if (aw_idx == ids_pkg::IDX_DRIVE) begin
				next_drive_reg = w_data[NCH-1:0]; // R2
			end
		end
		// forwarded while high, held while low, caught up on return high
		next_drive_out = strobe.level ? drive_reg : drive_out; // R1 R2 R21
	end

	// read channel: answered one cycle after the address is taken
	always_comb begin
		read_fire = s_axi_arvalid & s_axi_arready;
		rd_idx = s_axi_araddr[ids_pkg::IDX_LSB +: ids_pkg::IDX_W];
		rd_chan = rd_idx - ids_pkg::IDX_CHAN_FIRST;
		next_rvalid = s_axi_rvalid & ~s_axi_rready;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		// unmapped indices answer with an error and zero data
		if (read_fire) begin
			next_rvalid = 1'b1;
			next_rdata = '0;
			next_rresp = ids_pkg::RESP_OKAY;
			if (rd_idx == ids_pkg::IDX_GLOBAL_CONFIG) begin
				next_rdata[ids_pkg::CFG_FREEZE_BIT] = cfg.diag_freeze_enable;
				next_rdata[ids_pkg::CFG_RESYNC_BIT] = cfg.resync_select;
			end else if (rd_idx == ids_pkg::IDX_DRIVE) begin
				next_rdata[NCH-1:0] = drive_reg;
			end else if (rd_idx == ids_pkg::IDX_COLLECTIVE) begin
				next_rdata[NCH-1:0] = col;
				next_rdata[ids_pkg::COL_CF_BIT] = common_fault_flag;
			end else if (rd_idx >= ids_pkg::IDX_CHAN_FIRST && rd_idx <= ids_pkg::IDX_CHAN_LAST) begin
				next_rdata[CW-1:0] = chan_reg[rd_chan[CIW-1:0]];
			end else if (rd_idx == ids_pkg::IDX_STATUS) begin
				next_rdata[ids_pkg::STAT_STROBE_BIT] = strobe.level;
				next_rdata[ids_pkg::STAT_ISO_BIT] = iso_en;
				next_rdata[ids_pkg::STAT_DRIVE_LSB +: NCH] = drive_out;
			end else begin
				next_rresp = ids_pkg::RESP_SLVERR;
			end
		end
		next_arready = ~next_rvalid;
	end

	// diagnostic mode decode
	always_comb begin
		iso_en = cfg.diag_freeze_enable & ~cfg.resync_select; // R7 R8
		live = ~iso_en | strobe.level; // R7 R13
		col_read = read_fire & (rd_idx == ids_pkg::IDX_COLLECTIVE); // R3 R19
		col_read_live = col_read & live; // R4 R5
		col_read_frozen = col_read & ~live; // R17
		chan_load = col_read_live | (iso_en & (strobe.rise | strobe.fall)); // R10 R12
	end

	// per-channel sticky capture, delivery and collective bit
	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_chan
			logic [DW-1:0] clr_mask;
			logic [DW-1:0] delivered;
			logic drop_entry;
			assign delivered = chan_reg[ch][DW-1:0];
			// live read clears all, frozen read clears only what was delivered
			assign clr_mask = col_read_live ? {DW{1'b1}}
				: (col_read_frozen ? delivered : {DW{1'b0}}); // R6 R16
			// set wins over clear, so an active fault survives the read
			assign next_sticky[ch] = (sticky[ch] & ~clr_mask)
				| fault_in[ch*DW +: DW]; // R6 R11 R15 R18
			assign next_chan_reg[ch] = chan_load
				? {gated_led_status[ch], sticky[ch]} : chan_reg[ch]; // R4 R10 R12 R17
			assign drop_entry = col_read_frozen & (|delivered)
				& ~(|(next_sticky[ch] & delivered)); // R16
			// collective bit follows sticky while live, else holds or drops
			always_comb begin
				if (live) begin
					next_col[ch] = |next_sticky[ch]; // R12 R13 R14 R18
				end else if (drop_entry) begin
					next_col[ch] = 1'b0; // R16
				end else begin
					next_col[ch] = col[ch]; // R9
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sticky[ch] <= '0;
					chan_reg[ch] <= '0;
				end else begin
					sticky[ch] <= next_sticky[ch];
					chan_reg[ch] <= next_chan_reg[ch];
				end
			end
		end
	endgenerate

	// common fault follows the collective bits, so it freezes with them
	always_comb begin
		next_cf = |next_col; // R9
	end

	// bus handshake registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ids_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= ids_pkg::RESP_OKAY;
			s_axi_rdata <= '0;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_idx <= '0;
			w_data <= '0;
			w_lane0 <= 1'b0;
		end else begin
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rresp <= next_rresp;
			s_axi_rdata <= next_rdata;
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_idx <= next_aw_idx;
			w_data <= next_w_data;
			w_lane0 <= next_w_lane0;
		end
	end

	// user register state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= ids_pkg::CFG_RESET;
			drive_reg <= ids_pkg::DRIVE_RESET;
			drive_out <= ids_pkg::DRIVE_RESET;
		end else begin
			cfg <= next_cfg;
			drive_reg <= next_drive_reg;
			drive_out <= next_drive_out;
		end
	end

	// collective and common fault
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			col <= '0;
			common_fault_flag <= 1'b0;
		end else begin
			col <= next_col;
			common_fault_flag <= next_cf;
		end
	end
endmodule // ids_drive_diag

// >>> sim/ids_drive_diag_assertions.sv
// Purpose: port timing checks for the drive and diagnostic block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every instance of the block
module ids_drive_diag_assertions #(
	parameter int NCH = ids_pkg::NCH,
	parameter int DW = ids_pkg::DW
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic [ids_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic [ids_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic strobe_in,
	input wire logic [NCH*DW-1:0] fault_in,
	input wire logic [NCH-1:0] drive_out,
	input wire logic common_fault_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] quiet;
	logic [1:0] next_quiet;
	// cycles since the last read, saturating
	always_comb begin
		next_quiet = quiet;
		if (s_axi_arvalid && s_axi_arready)
			next_quiet = 2'h0;
		else if (quiet != 2'h3)
			next_quiet = quiet + 2'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			quiet <= 2'h0;
		else
			quiet <= next_quiet;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (write_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two cycles after request");
	a_read_answer: assert property (read_taken |=> s_axi_rvalid)
		else $error("read data not one cycle after request");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_unmapped_read: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > 4'hb)
		|=> s_axi_rresp == ids_pkg::RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");
	a_drive_frozen: assert property (!strobe_in [*3] |=> $stable(drive_out))
		else $error("drive output moved while strobe low");
	a_fault_to_cf: assert property (strobe_in [*3] ##0 (|fault_in) |-> ##[1:2] common_fault_flag)
		else $error("fault not shown on common fault");
	a_cf_sticky: assert property ((strobe_in [*6] ##0 (common_fault_flag && quiet == 2'h3
		&& !(s_axi_arvalid && s_axi_arready)))
		|=> common_fault_flag)
		else $error("common fault cleared without a read");
endmodule // ids_drive_diag_assertions

bind ids_drive_diag ids_drive_diag_assertions #(.NCH(NCH), .DW(DW)) u_ids_drive_diag_assertions (.*);

// >>> sim/ids_host_strobe.sv
// Purpose: host model that drives the strobe pin
// Assumes: level requests come from the bench
// Notes: pin idles high and changes just after a clock edge
module ids_host_strobe (
	input wire logic aclk,
	input wire logic want_high,
	output logic strobe_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial strobe_in = 1'b1;
	always @(posedge aclk) begin
		strobe_in <= want_high;
	end
endmodule // ids_host_strobe

// >>> sim/ids_drive_diag_tb_top.sv
// Purpose: self-checking bench for the drive and diagnostic block
// Assumes: strobe from the host model, registers over AXI4-Lite
// Notes: collective register is always read before channel registers
module ids_drive_diag_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, fault_in, got;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [7:0] gated_led_status, drive_out;
	logic strobe_in, want_high, common_fault_flag;
	int fail_count, n_compared, cycles;
	typedef struct packed {
		logic [5:0] addr;
		logic [31:0] wd;
		logic [31:0] exp;
		logic [1:0] rsp;
	} ids_row_type;
	ids_row_type rows [4];
	ids_drive_diag u_ids_drive_diag (.*);
	ids_host_strobe u_ids_host_strobe (.*);
	task automatic end_of_test();
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		got = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
		check(got, e);
	endtask
	task automatic strobe(input logic v);
		want_high <= v;
		repeat (6) @(posedge aclk);
	endtask
	task automatic pulse(input logic [31:0] f);
		fault_in <= f;
		repeat (2) @(posedge aclk);
		fault_in <= '0;
		repeat (4) @(posedge aclk);
	endtask
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, fault_in} = '0;
		s_axi_wstrb = 4'hf;
		gated_led_status = 8'h01;
		want_high = 1'b1;
		aresetn = 1'b0;
		rows = '{'{6'h00, 32'h3, 32'h3, ids_pkg::RESP_OKAY},
			'{6'h04, 32'ha5, 32'ha5, ids_pkg::RESP_OKAY},
			'{6'h08, 32'hff, 32'h0, ids_pkg::RESP_OKAY},
			'{6'h30, 32'h1, 32'h0, ids_pkg::RESP_SLVERR}};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(32'(drive_out), 32'h0);
		check(32'(common_fault_flag), 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wd);
			check(32'(resp), 32'(rows[i].rsp));
			rd(rows[i].addr, rows[i].exp);
			check(32'(resp), 32'(rows[i].rsp));
		end
		s_axi_wstrb <= 4'he;
		wr(6'h04, 32'h0);
		check(32'(resp), 32'(ids_pkg::RESP_OKAY));
		s_axi_wstrb <= 4'hf;
		rd(6'h04, 32'ha5);
		check(32'(drive_out), 32'ha5);
		rd(6'h2c, 32'ha501);
		wr(6'h00, 32'h1);
		rd(6'h2c, 32'ha503);
		wr(6'h00, 32'h0);
		strobe(1'b0);
		wr(6'h04, 32'h3c);
		check(32'(drive_out), 32'ha5);
		strobe(1'b1);
		check(32'(drive_out), 32'h3c);
		fault_in <= 32'h1;
		repeat (3) @(posedge aclk);
		check(32'(common_fault_flag), 32'h1);
		rd(6'h08, 32'h101);
		rd(6'h08, 32'h101);
		fault_in <= '0;
		repeat (2) @(posedge aclk);
		rd(6'h08, 32'h101);
		rd(6'h0c, 32'h11);
		rd(6'h08, 32'h0);
		rd(6'h0c, 32'h10);
		check(32'(common_fault_flag), 32'h0);
		strobe(1'b0);
		pulse(32'h1000);
		rd(6'h08, 32'h108);
		rd(6'h18, 32'h1);
		strobe(1'b1);
		wr(6'h00, 32'h1);
		strobe(1'b0);
		pulse(32'h20);
		check(32'(common_fault_flag), 32'h0);
		rd(6'h08, 32'h0);
		rd(6'h10, 32'h0);
		strobe(1'b1);
		rd(6'h08, 32'h102);
		rd(6'h10, 32'h2);
		rd(6'h08, 32'h0);
		pulse(32'h400);
		check(32'(common_fault_flag), 32'h1);
		strobe(1'b0);
		rd(6'h08, 32'h104);
		rd(6'h08, 32'h0);
		rd(6'h14, 32'h4);
		strobe(1'b1);
		rd(6'h08, 32'h0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(32'(drive_out), 32'h0);
		check(32'(common_fault_flag), 32'h0);
		rd(6'h04, 32'h0);
		rd(6'h2c, 32'h1);
		end_of_test();
	end
endmodule // ids_drive_diag_tb_top
